/* dac_cfg.svh */
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DAC_ADDR_W 32
`define DAC_CODE_W 8
`define DAC_BIT_IDX_W 3
`define DAC_CHANNELS 2

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DAC_VALUE_CH0_OFS 32'hfffff280
`define DAC_VALUE_CH1_OFS 32'h0ffff281
`define DAC_MODE_CTRL_OFS 32'hfffff282

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DAC_MODE_RESET 8'h00
`define DAC_VALUE_RESET 8'h00
`define DAC_RDATA_RESET 8'h00

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define DAC_REALTIME_SELECT_CH0_BIT 0
`define DAC_REALTIME_SELECT_CH1_BIT 1
`define DAC_CONV_ENABLE_CH0_BIT 4
`define DAC_CONV_ENABLE_CH1_BIT 5
`define DAC_MODE_WRITABLE_MASK 8'h33

`endif

/* dac_channel.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"

module dac_channel (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic realtime_i,
  input wire logic wr_i,
  input wire logic [`DAC_CODE_W-1:0] wdata_i,
  input wire logic trigger_i,
  input wire logic stop_i,
  output logic [`DAC_CODE_W-1:0] value_o,
  output logic [`DAC_CODE_W-1:0] code_o,
  output logic valid_o,
  output logic oe_o,
  output logic conv_o
);
  import dac_pkg::*;

  chan_state_s st_reg;
  chan_state_s st_next;
  logic [`DAC_CODE_W-1:0] src;

  // A conversion needs an enabled, running converter and a mode-specific trigger
  always_comb begin
    conv_o = 1'b0;
    if (enable_i && !stop_i) begin
      if (realtime_i) begin
        conv_o = trigger_i;
      end else begin
        conv_o = wr_i || !st_reg.en_q;
      end
    end
    // Normal mode converts the word being written, not the stale one
    src = (!realtime_i && wr_i) ? wdata_i : st_reg.value;
  end

  always_comb begin
    st_next = st_reg;
    // Enable edges seen during stop are held back until it ends
    st_next.en_q = stop_i ? st_reg.en_q : enable_i;
    if (wr_i) begin
      st_next.value = wdata_i;
    end
    if (!enable_i) begin
      st_next.valid = 1'b0;
    end
    if (conv_o) begin
      st_next.code = src;
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{value: `DAC_VALUE_RESET, code: `DAC_VALUE_RESET, valid: 1'b0, en_q: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign value_o = st_reg.value;
  assign code_o = st_reg.code;
  assign valid_o = st_reg.valid;
  // Pin is released while disabled or in stop; the ladder then floats
  assign oe_o = enable_i && !stop_i;

endmodule : dac_channel
`default_nettype wire

/* dac_control.sv */
//
// Notes on behaviour
// - Each channel holds an 8-bit code; output level is reference times code over 256.
// - Mode register resets to zero; byte or single-bit reads and writes.
// - Mode bit 4 enables channel 0, bit 5 channel 1; bits 7,6,3,2 read zero.
// - Mode bit 0/1 pick channel 0/1 mode: 0 normal, 1 real-time.
// - Both value registers reset to zero; whole-byte access only.
// - Real-time: channel 0 fires on timer 2 compare, channel 1 on timer 3.
// - Normal mode: each value write converts the newly written code.
// - Normal mode: setting the enable bit converts the code already held.
// - Each channel holds its last conversion until its next one.
// - Real-time: each timer trigger moves the value register to the output.
// - Real-time: output undefined from enabling until the first trigger.
// - Deepest stop: converter halts and both outputs go high impedance.
// - Idle and subclock modes: converter keeps running.
//
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"

module dac_control (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire dac_pkg::bus_req_s bus_i,
  output logic [`DAC_CODE_W-1:0] rdata_o,
  input wire logic timer2_compare_event_i,
  input wire logic timer3_compare_event_i,
  input wire logic stop_mode_i,
  input wire logic idle_mode_i,
  output logic [`DAC_CODE_W-1:0] analog_out_ch0_o,
  output logic [`DAC_CODE_W-1:0] analog_out_ch1_o,
  output logic analog_out_ch0_oe_o,
  output logic analog_out_ch1_oe_o,
  output logic analog_out_ch0_valid_o,
  output logic analog_out_ch1_valid_o
);
  import dac_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_mode;
  logic sel_ch0;
  logic sel_ch1;
  logic mode_wr;
  logic [`DAC_CODE_W-1:0] dac_mode_control;

  assign sel_mode = (bus_i.addr == `DAC_MODE_CTRL_OFS);
  assign sel_ch0 = (bus_i.addr == `DAC_VALUE_CH0_OFS);
  assign sel_ch1 = (bus_i.addr == `DAC_VALUE_CH1_OFS);
  assign mode_wr = bus_i.wr && sel_mode;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  dac_mode_reg u_mode (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_i(mode_wr),
    .bit_en_i(bus_i.bit_en),
    .bit_idx_i(bus_i.bit_idx),
    .wdata_i(bus_i.wdata),
    .mode_o(dac_mode_control)
  );

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [`DAC_CHANNELS-1:0] conv_enable_chan;
  logic [`DAC_CHANNELS-1:0] realtime_select_chan;
  logic [`DAC_CHANNELS-1:0] trig;
  logic [`DAC_CHANNELS-1:0] val_wr;
  logic [`DAC_CHANNELS-1:0] conv;
  logic [`DAC_CHANNELS-1:0] valid;
  logic [`DAC_CHANNELS-1:0] oe;
  logic [`DAC_CODE_W-1:0] dac_value_chan [`DAC_CHANNELS];
  logic [`DAC_CODE_W-1:0] code [`DAC_CHANNELS];

  assign conv_enable_chan[0] = dac_mode_control[`DAC_CONV_ENABLE_CH0_BIT];
  assign conv_enable_chan[1] = dac_mode_control[`DAC_CONV_ENABLE_CH1_BIT];
  assign realtime_select_chan[0] = dac_mode_control[`DAC_REALTIME_SELECT_CH0_BIT];
  assign realtime_select_chan[1] = dac_mode_control[`DAC_REALTIME_SELECT_CH1_BIT];
  assign trig[0] = timer2_compare_event_i;
  assign trig[1] = timer3_compare_event_i;
  // Bit-wide writes to value registers are ignored
  assign val_wr[0] = bus_i.wr && !bus_i.bit_en && sel_ch0;
  assign val_wr[1] = bus_i.wr && !bus_i.bit_en && sel_ch1;

  // Each channel sees only its own enable, mode, write and trigger
  genvar g;
  generate
    for (g = 0; g < `DAC_CHANNELS; g++) begin : g_chan
      dac_channel u_chan (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(conv_enable_chan[g]),
        .realtime_i(realtime_select_chan[g]),
        .wr_i(val_wr[g]),
        .wdata_i(bus_i.wdata),
        .trigger_i(trig[g]),
        .stop_i(stop_mode_i),
        .value_o(dac_value_chan[g]),
        .code_o(code[g]),
        .valid_o(valid[g]),
        .oe_o(oe[g]),
        .conv_o(conv[g])
      );
    end
  endgenerate

  // The ladder turns each held code into reference * code / 256
  assign analog_out_ch0_o = code[0];
  assign analog_out_ch1_o = code[1];
  assign analog_out_ch0_oe_o = oe[0];
  assign analog_out_ch1_oe_o = oe[1];
  assign analog_out_ch0_valid_o = valid[0];
  assign analog_out_ch1_valid_o = valid[1];

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  top_state_s st_reg;
  top_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (bus_i.rd) begin
      // A single-bit read returns the whole byte; unmapped reads give zero
      if (sel_mode) begin
        st_next.rdata = dac_mode_control;
      end else if (sel_ch0) begin
        st_next.rdata = dac_value_chan[0];
      end else if (sel_ch1) begin
        st_next.rdata = dac_value_chan[1];
      end else begin
        st_next.rdata = `DAC_RDATA_RESET;
      end
    end else begin
      st_next.rdata = `DAC_RDATA_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{rdata: `DAC_RDATA_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_mode_byte_write: assert property (
    mode_wr && !bus_i.bit_en
    |=> dac_mode_control == ($past(bus_i.wdata) & `DAC_MODE_WRITABLE_MASK))
    else $error("mode byte write not stored");

  a_mode_bit_write: assert property (
    mode_wr && bus_i.bit_en && bus_i.bit_idx == 3'h4
    |=> conv_enable_chan[0] == $past(bus_i.wdata[0])
        && realtime_select_chan == $past(realtime_select_chan))
    else $error("mode bit write disturbed other bits");

  a_mode_reserved_zero: assert property (
    (dac_mode_control & ~`DAC_MODE_WRITABLE_MASK) == 8'h00)
    else $error("reserved mode bit reads one");

  a_mode_read_back: assert property (
    bus_i.rd && sel_mode |=> rdata_o == $past(dac_mode_control))
    else $error("mode read data wrong");

  a_value_byte_write: assert property (
    val_wr[0] |=> dac_value_chan[0] == $past(bus_i.wdata))
    else $error("value write not stored");

  a_value_bit_ignored: assert property (
    bus_i.wr && bus_i.bit_en && sel_ch1 |=> $stable(dac_value_chan[1]))
    else $error("bit write changed a value register");

  a_value_read_back: assert property (
    bus_i.rd && sel_ch1 |=> rdata_o == $past(dac_value_chan[1]))
    else $error("value read data wrong");

  a_normal_write_conv: assert property (
    conv_enable_chan[0] && !realtime_select_chan[0] && !stop_mode_i && val_wr[0]
    |=> code[0] == $past(bus_i.wdata) && valid[0])
    else $error("normal write did not convert new code");

  a_enable_rise_conv: assert property (
    $rose(conv_enable_chan[1]) && !realtime_select_chan[1] && !stop_mode_i
    && !$past(stop_mode_i) && !val_wr[1]
    |=> code[1] == $past(dac_value_chan[1]))
    else $error("enable did not convert held code");

  a_rt_trigger_conv: assert property (
    conv_enable_chan[0] && realtime_select_chan[0] && !stop_mode_i
    && timer2_compare_event_i
    |=> code[0] == $past(dac_value_chan[0]) && valid[0])
    else $error("timer trigger did not transfer value");

  a_rt_ignores_write: assert property (
    conv_enable_chan[1] && realtime_select_chan[1] && !timer3_compare_event_i
    && val_wr[1] |=> $stable(code[1]))
    else $error("real-time channel converted on a write");

  a_rt_wrong_timer: assert property (
    realtime_select_chan[0] && timer3_compare_event_i && !timer2_compare_event_i
    |=> $stable(code[0]))
    else $error("channel 0 fired on timer 3");

  a_hold_output: assert property (
    !conv[1] |=> $stable(code[1]))
    else $error("output changed without conversion");

  a_rt_undefined: assert property (
    conv_enable_chan[0] && realtime_select_chan[0] && !valid[0]
    && !timer2_compare_event_i |=> !valid[0])
    else $error("real-time output marked valid before trigger");

  a_stop_hiz: assert property (
    stop_mode_i |-> !analog_out_ch0_oe_o && !analog_out_ch1_oe_o && conv == 2'b00)
    else $error("output driven or converting in stop");

  a_idle_runs: assert property (
    idle_mode_i && !stop_mode_i && conv_enable_chan[0] |-> analog_out_ch0_oe_o)
    else $error("converter halted in idle");

  a_chan_independent: assert property (
    val_wr[1] && !val_wr[0] |=> $stable(dac_value_chan[0]))
    else $error("channel 1 write touched channel 0");

  // ----------------------------------------------------------------
  // Mirror checks for the other channel, then read-data, disable and stop checks; the covers are channel 0 only, except real-time which covers both
  // ----------------------------------------------------------------
  a_value1_byte_write: assert property (
    val_wr[1] |=> dac_value_chan[1] == $past(bus_i.wdata))
    else $error("value 1 write not stored");

  a_value0_bit_ignored: assert property (
    bus_i.wr && bus_i.bit_en && sel_ch0 |=> $stable(dac_value_chan[0]))
    else $error("bit write changed value 0");

  a_value0_read_back: assert property (
    bus_i.rd && sel_ch0 |=> rdata_o == $past(dac_value_chan[0]))
    else $error("value 0 read data wrong");

  a_rdata_idle: assert property (
    !bus_i.rd |=> rdata_o == `DAC_RDATA_RESET)
    else $error("read data not cleared after read");

  a_unmapped_read: assert property (
    bus_i.rd && !sel_mode && !sel_ch0 && !sel_ch1 |=> rdata_o == `DAC_RDATA_RESET)
    else $error("unmapped read returned data");

  a_mode_bit1_write: assert property (
    mode_wr && bus_i.bit_en && bus_i.bit_idx == 3'h1
    |=> realtime_select_chan[1] == $past(bus_i.wdata[0])
        && conv_enable_chan == $past(conv_enable_chan))
    else $error("mode bit 1 write wrong");

  a_normal_write_conv1: assert property (
    conv_enable_chan[1] && !realtime_select_chan[1] && !stop_mode_i && val_wr[1]
    |=> code[1] == $past(bus_i.wdata) && valid[1])
    else $error("normal write did not convert channel 1");

  a_enable_rise_conv0: assert property (
    $rose(conv_enable_chan[0]) && !realtime_select_chan[0] && !stop_mode_i
    && !$past(stop_mode_i) && !val_wr[0]
    |=> code[0] == $past(dac_value_chan[0]))
    else $error("enable did not convert channel 0 code");

  a_rt_trigger_conv1: assert property (
    conv_enable_chan[1] && realtime_select_chan[1] && !stop_mode_i
    && timer3_compare_event_i
    |=> code[1] == $past(dac_value_chan[1]) && valid[1])
    else $error("timer 3 did not transfer value");

  a_rt_undefined1: assert property (
    conv_enable_chan[1] && realtime_select_chan[1] && !valid[1]
    && !timer3_compare_event_i |=> !valid[1])
    else $error("channel 1 valid before its trigger");

  a_rt_wrong_timer1: assert property (
    realtime_select_chan[1] && timer2_compare_event_i && !timer3_compare_event_i
    |=> $stable(code[1]))
    else $error("channel 1 fired on timer 2");

  a_rt_ignores_write0: assert property (
    realtime_select_chan[0] && !timer2_compare_event_i && val_wr[0]
    |=> $stable(code[0]))
    else $error("real-time channel 0 converted on a write");

  a_hold_output0: assert property (
    !conv[0] |=> $stable(code[0]))
    else $error("channel 0 output changed without conversion");

  a_disabled_hold0: assert property (
    !conv_enable_chan[0] |=> !valid[0] && $stable(code[0]))
    else $error("disabled channel 0 converted");

  a_disabled_hold1: assert property (
    !conv_enable_chan[1] |=> !valid[1] && $stable(code[1]))
    else $error("disabled channel 1 converted");

  a_stop_holds_code: assert property (
    stop_mode_i |=> $stable(code[0]) && $stable(code[1]))
    else $error("code changed in stop");

  a_idle_runs1: assert property (
    idle_mode_i && !stop_mode_i && conv_enable_chan[1] |-> analog_out_ch1_oe_o)
    else $error("channel 1 halted in idle");

  a_chan_independent0: assert property (
    val_wr[0] && !val_wr[1] |=> $stable(dac_value_chan[1]))
    else $error("channel 0 write touched channel 1");

  c_normal_conv: cover property (
    conv_enable_chan[0] && !realtime_select_chan[0] && val_wr[0] ##1 valid[0]);

  c_rt_conv: cover property (
    conv_enable_chan[1] && realtime_select_chan[1] && timer3_compare_event_i ##1 valid[1]);

  c_stop_enabled: cover property (
    conv_enable_chan[0] && stop_mode_i ##1 !stop_mode_i);

  c_idle_running: cover property (
    idle_mode_i && conv[0]);

  c_rt_conv0: cover property (
    conv_enable_chan[0] && realtime_select_chan[0] && timer2_compare_event_i ##1 valid[0]);

endmodule : dac_control
`default_nettype wire

/* dac_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"

module dac_control_tb;
  import dac_pkg::*;
  localparam logic [`DAC_ADDR_W-1:0] ma = `DAC_MODE_CTRL_OFS;
  localparam logic [`DAC_ADDR_W-1:0] a0 = `DAC_VALUE_CH0_OFS;
  localparam logic [`DAC_ADDR_W-1:0] a1 = `DAC_VALUE_CH1_OFS;
  logic clk_i;
  logic reset_n_i;
  bus_req_s bus_i;
  logic t2;
  logic t3;
  logic stop_mode_i;
  logic idle_mode_i;
  logic [7:0] rdata_o;
  logic [7:0] out0;
  logic [7:0] out1;
  logic oe0;
  logic oe1;
  logic v0;
  logic v1;
  int errors;
  int n_compared;

  dac_control dac_control_inst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .timer2_compare_event_i(t2),
    .timer3_compare_event_i(t3),
    .stop_mode_i(stop_mode_i),
    .idle_mode_i(idle_mode_i),
    .analog_out_ch0_o(out0),
    .analog_out_ch1_o(out1),
    .analog_out_ch0_oe_o(oe0),
    .analog_out_ch1_oe_o(oe1),
    .analog_out_ch0_valid_o(v0),
    .analog_out_ch1_valid_o(v1)
  );

  dac_timer_model dac_timer_model_inst (
    .clk_i(clk_i),
    .timer2_compare_event_o(t2),
    .timer3_compare_event_o(t3)
  );

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8

  task automatic cmp1(input string n, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask : cmp1

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b, input logic [2:0] i);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.bit_en <= b;
    bus_i.bit_idx <= i;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
    bus_i.bit_en <= 1'b0;
  endtask : wr

  // Read data stand in one cycle only, so the idle value is checked too
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 cmp8(n, e, rdata_o);
    @(posedge clk_i);
    #1 cmp8("rdata idle", 8'h00, rdata_o);
  endtask : rd

  task automatic chan(input logic c, input logic [7:0] e, input logic v, input logic o);
    cmp8(c ? "code1" : "code0", e, c ? out1 : out0);
    cmp1(c ? "valid1" : "valid0", v, c ? v1 : v0);
    cmp1(c ? "oe1" : "oe0", o, c ? oe1 : oe0);
  endtask : chan

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(ma, 8'h00, "mode");
    rd(a0, 8'h00, "value0");
    rd(a1, 8'h00, "value1");
    chan(0, 8'h00, 0, 0);
    chan(1, 8'h00, 0, 0);
  endtask : t_reset

  task automatic t_mode();
    wr(ma, 8'hcc, 0, 0);
    rd(ma, 8'h00, "mode reserved");
    wr(ma, 8'h01, 1, 1);
    rd(ma, 8'h02, "mode bit set");
    wr(ma, 8'h00, 1, 1);
    rd(ma, 8'h00, "mode bit clear");
    chan(1, 8'h00, 0, 0);
  endtask : t_mode

  task automatic t_normal();
    wr(a0, 8'ha5, 0, 0);
    tick(2);
    chan(0, 8'h00, 0, 0);
    wr(ma, 8'h01, 1, 4);
    tick(2);
    chan(0, 8'ha5, 1, 1);
    wr(a0, 8'hff, 0, 0);
    tick(2);
    chan(0, 8'hff, 1, 1);
    wr(a0, 8'h00, 0, 0);
    wr(a0, 8'h5a, 0, 0);
    tick(2);
    chan(0, 8'h5a, 1, 1);
    dac_timer_model_inst.fire(1, 0);
    tick(4);
    chan(0, 8'h5a, 1, 1);
    chan(1, 8'h00, 0, 0);
    rd(a0, 8'h5a, "value0");
  endtask : t_normal

  // Channel 1 in real-time mode: mode set while disabled, value loaded first
  task automatic t_realtime();
    wr(ma, 8'h01, 1, 1);
    wr(a1, 8'h3c, 0, 0);
    wr(ma, 8'h01, 1, 5);
    tick(2);
    cmp1("valid1", 1'b0, v1);
    cmp1("oe1", 1'b1, oe1);
    dac_timer_model_inst.fire(1, 0);
    tick(2);
    cmp1("valid1", 1'b0, v1);
    chan(0, 8'h5a, 1, 1);
    dac_timer_model_inst.fire(0, 1);
    tick(2);
    chan(1, 8'h3c, 1, 1);
    wr(a1, 8'hc3, 0, 0);
    tick(2);
    chan(1, 8'h3c, 1, 1);
    dac_timer_model_inst.fire(1, 1);
    tick(2);
    chan(1, 8'hc3, 1, 1);
    chan(0, 8'h5a, 1, 1);
    rd(ma, 8'h32, "mode");
  endtask : t_realtime

  task automatic t_standby();
    @(posedge clk_i);
    idle_mode_i <= 1'b1;
    wr(a0, 8'h11, 0, 0);
    tick(2);
    chan(0, 8'h11, 1, 1);
    @(posedge clk_i);
    stop_mode_i <= 1'b1;
    tick(1);
    cmp1("oe0 stop", 1'b0, oe0);
    cmp1("oe1 stop", 1'b0, oe1);
    dac_timer_model_inst.fire(0, 1);
    tick(2);
    cmp8("code1 stop", 8'hc3, out1);
    cmp8("code0 stop", 8'h11, out0);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    idle_mode_i <= 1'b0;
    tick(1);
    cmp1("oe0 resume", 1'b1, oe0);
  endtask : t_standby

  task automatic t_refused();
    wr(32'hfffff283, 8'hff, 0, 0);
    rd(32'hfffff283, 8'h00, "unmapped");
    wr(a1, 8'h00, 1, 0);
    rd(a1, 8'hc3, "value1 bit write");
    wr(a0, 8'h00, 1, 0);
    rd(a0, 8'h11, "value0 bit write");
  endtask : t_refused

  // Each channel swaps mode with its enable cleared first
  task automatic t_swap();
    wr(ma, 8'h00, 1, 4);
    wr(ma, 8'h01, 1, 0);
    wr(ma, 8'h00, 1, 5);
    wr(ma, 8'h00, 1, 1);
    wr(a0, 8'h66, 0, 0);
    wr(a1, 8'h77, 0, 0);
    wr(ma, 8'h01, 1, 4);
    wr(ma, 8'h01, 1, 5);
    tick(2);
    chan(0, 8'h11, 0, 1);
    chan(1, 8'h77, 1, 1);
    dac_timer_model_inst.fire(0, 1);
    tick(2);
    chan(0, 8'h11, 0, 1);
    dac_timer_model_inst.fire(1, 0);
    tick(2);
    chan(0, 8'h66, 1, 1);
    wr(a1, 8'h88, 0, 0);
    tick(2);
    chan(1, 8'h88, 1, 1);
    rd(ma, 8'h31, "mode swapped");
  endtask : t_swap

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("Error watchdog expired");
    test_done();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    reset_n_i = 1'b0;
    bus_i = '0;
    stop_mode_i = 1'b0;
    idle_mode_i = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_mode();
    t_normal();
    t_realtime();
    t_standby();
    t_refused();
    t_swap();
    test_done();
  end
endmodule : dac_control_tb

`default_nettype wire

/* dac_mode_reg.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"

module dac_mode_reg (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic bit_en_i,
  input wire logic [`DAC_BIT_IDX_W-1:0] bit_idx_i,
  input wire logic [`DAC_CODE_W-1:0] wdata_i,
  output logic [`DAC_CODE_W-1:0] mode_o
);
  import dac_pkg::*;

  mode_state_s st_reg;
  mode_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      if (bit_en_i) begin
        // Single-bit access uses data bit 0 as the new value
        st_next.mode[bit_idx_i] = wdata_i[0];
      end else begin
        st_next.mode = wdata_i;
      end
      // Reserved positions never hold a one
      st_next.mode = st_next.mode & `DAC_MODE_WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{mode: `DAC_MODE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign mode_o = st_reg.mode;

endmodule : dac_mode_reg
`default_nettype wire

/* dac_pkg.sv */
`default_nettype none
`include "dac_cfg.svh"

package dac_pkg;

  // Register bus request carried as one bundle
  typedef struct packed {
    logic [`DAC_ADDR_W-1:0] addr;
    logic [`DAC_CODE_W-1:0] wdata;
    logic wr;
    logic rd;
    logic bit_en;
    logic [`DAC_BIT_IDX_W-1:0] bit_idx;
  } bus_req_s;

  typedef struct packed {
    logic [`DAC_CODE_W-1:0] value;
    logic [`DAC_CODE_W-1:0] code;
    logic valid;
    logic en_q;
  } chan_state_s;

  typedef struct packed {
    logic [`DAC_CODE_W-1:0] mode;
  } mode_state_s;

  typedef struct packed {
    logic [`DAC_CODE_W-1:0] rdata;
  } top_state_s;

endpackage : dac_pkg
`default_nettype wire

/* dac_timer_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Compare-event source standing in for timer units 2 and 3
// ----------------------------------------------------------------
module dac_timer_model (
  input wire logic clk_i,
  output logic timer2_compare_event_o,
  output logic timer3_compare_event_o
);
  initial begin
    timer2_compare_event_o = 1'b0;
    timer3_compare_event_o = 1'b0;
  end

  // One-cycle pulse; both timers may fire on the same edge
  task automatic fire(input logic t2, input logic t3);
    @(posedge clk_i);
    timer2_compare_event_o <= t2;
    timer3_compare_event_o <= t3;
    @(posedge clk_i);
    timer2_compare_event_o <= 1'b0;
    timer3_compare_event_o <= 1'b0;
  endtask : fire
endmodule : dac_timer_model

`default_nettype wire
